// ===== core/dsd_pkg.sv
// Package: constants for the data-space address decoder
package dsd_pkg;
  // ---------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_BASE   = 16'h0000;
  localparam logic [15:0] REG_COUNT  = 16'h0020;
  localparam logic [15:0] SIO_BASE   = 16'h0020;
  localparam logic [15:0] SIO_COUNT  = 16'h0040;
  localparam logic [15:0] XIO_BASE   = 16'h0060;
  localparam logic [15:0] XIO_LAST   = 16'h00FF;
  localparam logic [15:0] SRAM_BASE  = 16'h0100;
  localparam logic [15:0] SRAM_1K    = 16'h0400;
  localparam logic [15:0] SRAM_512   = 16'h0200;
  localparam logic [15:0] SRAM_2K    = 16'h0800;
  localparam logic [15:0] PGM_BASE   = 16'h4000;
  localparam logic [15:0] PGM_LAST   = 16'hBFFF;
  localparam logic [5:0]  DISP_MAX   = 6'h3F;
  // ---------------------------------------------------------------
  // Standard I/O offsets (I/O-transfer numbering)
  // ---------------------------------------------------------------
  localparam logic [5:0]  SCR0_IO    = 6'h1E;
  localparam logic [5:0]  SCR1_IO    = 6'h2A;
  localparam logic [5:0]  SCR2_IO    = 6'h2B;
  localparam logic [5:0]  FDATA_IO   = 6'h20;
  localparam logic [5:0]  FADRL_IO   = 6'h21;
  localparam logic [5:0]  FADRH_IO   = 6'h22;
  localparam logic [5:0]  FCTRL_IO   = 6'h1F;
  localparam logic [5:0]  FCFG_IO    = 6'h36;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  // ---------------------------------------------------------------
  // Program flash size in KB with emulated E2PROM disabled
  // ---------------------------------------------------------------
  localparam logic [5:0]  PGM_FULL_KB = 6'h20;
  // ---------------------------------------------------------------
  // Access kinds and targets
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ACC_DATA = 3'h1,
    ACC_IOX  = 3'h2,
    ACC_PML  = 3'h4
  } dsd_acc_t;
  typedef enum logic [6:0]
  {
    TGT_REG  = 7'h01,
    TGT_SIO  = 7'h02,
    TGT_XIO  = 7'h04,
    TGT_SRAM = 7'h08,
    TGT_PGM  = 7'h10,
    TGT_HOLE = 7'h20,
    TGT_NONE = 7'h40
  } dsd_tgt_t;
  // Pointer selects
  localparam logic [1:0]  PTR_NONE = 2'h0;
  localparam logic [1:0]  PTR_X    = 2'h1;
  localparam logic [1:0]  PTR_Y    = 2'h2;
  localparam logic [1:0]  PTR_Z    = 2'h3;
endpackage

// ===== core/dsd_ea.sv
// Effective-address former for pointer and displacement access
`timescale 1ns/1ps
module dsd_ea
(
  input  wire logic [1:0]  ptr_sel,
  input  wire logic [15:0] direct_addr,
  input  wire logic [5:0]  disp,
  input  wire logic [7:0]  ptr_x_lo,
  input  wire logic [7:0]  ptr_x_hi,
  input  wire logic [7:0]  ptr_y_lo,
  input  wire logic [7:0]  ptr_y_hi,
  input  wire logic [7:0]  ptr_z_lo,
  input  wire logic [7:0]  ptr_z_hi,
  output logic      [15:0] eff_addr
);
  logic [15:0] base;
  always_comb
  begin
    // Pointers are little-endian register pairs
    case (ptr_sel)
      dsd_pkg::PTR_X: base = {ptr_x_hi, ptr_x_lo};
      dsd_pkg::PTR_Y: base = {ptr_y_hi, ptr_y_lo};
      dsd_pkg::PTR_Z: base = {ptr_z_hi, ptr_z_lo};
      default:        base = direct_addr;
    endcase
    // Displacement only reaches from the second and third pointers
    if (ptr_sel == dsd_pkg::PTR_Y || ptr_sel == dsd_pkg::PTR_Z)
      eff_addr = base + {10'h000, disp};
    else
      eff_addr = base;
  end
endmodule // dsd_ea

// ===== core/dsd_top.sv
// Data-space address decoder: core accesses to registers, I/O, SRAM, flash
`timescale 1ns/1ps
module dsd_top
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        req,
  input  wire logic        req_wr,
  input  wire logic [2:0]  req_kind,
  input  wire logic [1:0]  ptr_sel,
  input  wire logic [15:0] req_addr,
  input  wire logic [5:0]  req_disp,
  input  wire logic [7:0]  req_wdata,
  input  wire logic [1:0]  sram_size,
  input  wire logic        e2_enable,
  input  wire logic [1:0]  e2_split,
  input  wire logic [7:0]  ptr_x_lo,
  input  wire logic [7:0]  ptr_x_hi,
  input  wire logic [7:0]  ptr_y_lo,
  input  wire logic [7:0]  ptr_y_hi,
  input  wire logic [7:0]  ptr_z_lo,
  input  wire logic [7:0]  ptr_z_hi,
  input  wire logic        fc_busy,
  input  wire logic [7:0]  fc_rdata,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic [7:0]  sio_rdata,
  input  wire logic [7:0]  xio_rdata,
  input  wire logic [7:0]  sram_rdata,
  input  wire logic [15:0] pgm_rdata,
  output logic             rsp_valid,
  output logic      [7:0]  rsp_rdata,
  output logic      [6:0]  rsp_target,
  output logic             reg_sel_q,
  output logic             sio_sel_q,
  output logic             xio_sel_q,
  output logic             sram_sel_q,
  output logic             pgm_sel_q,
  output logic             fc_sel_q,
  output logic             wr_q,
  output logic      [15:0] local_addr_q,
  output logic      [7:0]  wdata_q,
  output logic      [14:0] pgm_word_addr_q,
  output logic             fc_start_q,
  output logic             fc_status_q,
  output logic      [5:0]  pgm_kb_q
);
  // -------------------------------------------------------------
  // Address formation
  // -------------------------------------------------------------
  logic [15:0] ea;
  dsd_ea u_ea
  (
    .ptr_sel     (ptr_sel),
    .direct_addr (req_addr),
    .disp        (req_disp),
    .ptr_x_lo    (ptr_x_lo),
    .ptr_x_hi    (ptr_x_hi),
    .ptr_y_lo    (ptr_y_lo),
    .ptr_y_hi    (ptr_y_hi),
    .ptr_z_lo    (ptr_z_lo),
    .ptr_z_hi    (ptr_z_hi),
    .eff_addr    (ea)
  );
  // -------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------
  logic [15:0] sram_len;
  logic [15:0] daddr;
  logic [5:0]  io_off;
  logic        is_fc;
  logic        is_scr;
  dsd_pkg::dsd_tgt_t tgt;
  always_comb
  begin
    case (sram_size)
      2'h0:    sram_len = dsd_pkg::SRAM_512;
      2'h2:    sram_len = dsd_pkg::SRAM_2K;
      default: sram_len = dsd_pkg::SRAM_1K;
    endcase
    // I/O transfers number the standard space from zero
    if (req_kind == dsd_pkg::ACC_IOX)
      daddr = {10'h000, req_addr[5:0]} + dsd_pkg::SIO_BASE;
    else
      daddr = ea;
    io_off = 6'(daddr - dsd_pkg::SIO_BASE);
    tgt    = dsd_pkg::TGT_NONE;
    if (req_kind == dsd_pkg::ACC_PML)
      tgt = dsd_pkg::TGT_PGM;
    else if (req_kind == dsd_pkg::ACC_IOX)
      tgt = dsd_pkg::TGT_SIO;
    else if (req_kind == dsd_pkg::ACC_DATA)
    begin
      if (daddr < dsd_pkg::REG_COUNT)
        tgt = dsd_pkg::TGT_REG;
      else if (daddr < dsd_pkg::SIO_BASE + dsd_pkg::SIO_COUNT)
        tgt = dsd_pkg::TGT_SIO;
      else if (daddr <= dsd_pkg::XIO_LAST)
        tgt = dsd_pkg::TGT_XIO;
      else if (daddr < dsd_pkg::SRAM_BASE + sram_len)
        tgt = dsd_pkg::TGT_SRAM;
      else if (daddr >= dsd_pkg::PGM_BASE && daddr <= dsd_pkg::PGM_LAST)
        tgt = dsd_pkg::TGT_PGM;
      else
        tgt = dsd_pkg::TGT_HOLE;
    end
    is_fc  = (tgt == dsd_pkg::TGT_SIO) && (io_off == dsd_pkg::FDATA_IO ||
             io_off == dsd_pkg::FADRL_IO || io_off == dsd_pkg::FADRH_IO ||
             io_off == dsd_pkg::FCTRL_IO || io_off == dsd_pkg::FCFG_IO);
    is_scr = (tgt == dsd_pkg::TGT_SIO) && (io_off == dsd_pkg::SCR0_IO ||
             io_off == dsd_pkg::SCR1_IO || io_off == dsd_pkg::SCR2_IO);
  end
  // -------------------------------------------------------------
  // Scratch registers and pipeline
  // -------------------------------------------------------------
  logic [7:0] scr_q [3];
  logic [7:0] scr_d [3];
  logic [1:0] scr_idx;
  logic       busy_s1_q, busy_s2_q, busy_s3_q;
  logic       pend_q, pend_d;
  logic [7:0] rsel_d;
  logic       hole_q, scr_hit_q, pml_q, eah_q;
  logic [1:0] sidx_q;
  logic [6:0] tgt_q;
  logic       ack_q;
  logic [5:0] kb_d;
  always_comb
  begin
    scr_idx = (io_off == dsd_pkg::SCR0_IO) ? 2'h0 :
              (io_off == dsd_pkg::SCR1_IO) ? 2'h1 : 2'h2;
    for (int i = 0; i < 3; i++)
      scr_d[i] = scr_q[i];
    if (req && req_wr && is_scr)
      scr_d[scr_idx] = req_wdata;
    // Twice the E2PROM size is withheld from program space
    case (e2_split)
      2'h0:    kb_d = 6'h1E;
      2'h1:    kb_d = 6'h1C;
      2'h2:    kb_d = 6'h18;
      default: kb_d = 6'h10;
    endcase
    if (!e2_enable)
      kb_d = dsd_pkg::PGM_FULL_KB;
    // A start request while busy stays pending; the event is not lost
    pend_d = pend_q;
    if (req && req_wr && is_fc && io_off == dsd_pkg::FCTRL_IO && req_wdata[1])
      pend_d = 1'b1;
    else if (fc_start_q)
      pend_d = 1'b0;
    case (1'b1)
      hole_q:    rsel_d = dsd_pkg::RST_BYTE;
      scr_hit_q: rsel_d = scr_q[sidx_q];
      pml_q:     rsel_d = eah_q ? pgm_rdata[15:8] : pgm_rdata[7:0];
      tgt_q[0]:  rsel_d = reg_rdata;
      tgt_q[1]:  rsel_d = fc_sel_q ? fc_rdata : sio_rdata;
      tgt_q[2]:  rsel_d = xio_rdata;
      tgt_q[3]:  rsel_d = sram_rdata;
      default:   rsel_d = dsd_pkg::RST_BYTE;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 3; i++)
        scr_q[i] <= dsd_pkg::RST_BYTE;
      {busy_s1_q, busy_s2_q, busy_s3_q} <= 3'h0;
      pend_q          <= 1'b0;
      fc_start_q      <= 1'b0;
      fc_status_q     <= 1'b0;
      {reg_sel_q, sio_sel_q, xio_sel_q, sram_sel_q, pgm_sel_q, fc_sel_q} <= 6'h00;
      wr_q            <= 1'b0;
      local_addr_q    <= 16'h0000;
      wdata_q         <= 8'h00;
      pgm_word_addr_q <= 15'h0000;
      pgm_kb_q        <= dsd_pkg::PGM_FULL_KB;
      {hole_q, scr_hit_q, pml_q, eah_q, ack_q} <= 5'h00;
      sidx_q          <= 2'h0;
      tgt_q           <= dsd_pkg::TGT_NONE;
      rsp_valid       <= 1'b0;
      rsp_rdata       <= 8'h00;
      rsp_target      <= dsd_pkg::TGT_NONE;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < 3; i++)
        scr_q[i] <= scr_d[i];
      busy_s1_q   <= fc_busy;
      busy_s2_q   <= busy_s1_q;
      busy_s3_q   <= busy_s2_q;
      if (busy_s2_q == busy_s3_q)
        fc_status_q <= busy_s3_q;
      pend_q      <= pend_d;
      fc_start_q  <= pend_q && !fc_status_q && !fc_start_q;
      pgm_kb_q    <= kb_d;
      reg_sel_q   <= req && tgt == dsd_pkg::TGT_REG;
      sio_sel_q   <= req && tgt == dsd_pkg::TGT_SIO && !is_scr;
      xio_sel_q   <= req && tgt == dsd_pkg::TGT_XIO;
      sram_sel_q  <= req && tgt == dsd_pkg::TGT_SRAM;
      pgm_sel_q   <= req && tgt == dsd_pkg::TGT_PGM && !req_wr;
      fc_sel_q    <= req && is_fc;
      wr_q        <= req && req_wr && tgt != dsd_pkg::TGT_HOLE && tgt != dsd_pkg::TGT_PGM;
      local_addr_q <= (tgt == dsd_pkg::TGT_SRAM) ? daddr - dsd_pkg::SRAM_BASE :
                      (tgt == dsd_pkg::TGT_SIO) ? {10'h000, io_off} : daddr;
      wdata_q     <= req_wdata;
      // Flash is 16 bits wide; the low address bit only picks the byte
      pgm_word_addr_q <= (req_kind == dsd_pkg::ACC_PML) ? daddr[15:1] :
                         15'(16'(daddr - dsd_pkg::PGM_BASE) >> 1);
      eah_q       <= daddr[0];
      hole_q      <= req && tgt == dsd_pkg::TGT_HOLE;
      scr_hit_q   <= req && is_scr;
      sidx_q      <= scr_idx;
      pml_q       <= req && tgt == dsd_pkg::TGT_PGM;
      tgt_q       <= req ? tgt : dsd_pkg::TGT_NONE;
      ack_q       <= req;
      rsp_valid   <= ack_q;
      rsp_rdata   <= rsel_d;
      rsp_target  <= tgt_q;
    end
  end
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  hole_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && hole_q |=> rsp_rdata == 8'h00)
    else $error("hole read not zero");
  xio_noiox_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req && req_kind == dsd_pkg::ACC_IOX |=> !xio_sel_q)
    else $error("extended io reached by io transfer");
  reg_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req && req_kind == dsd_pkg::ACC_DATA && ptr_sel == 2'h0 &&
    req_addr < 16'h0020 |=> reg_sel_q)
    else $error("register window missed");
  pgm_win_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req && !req_wr && req_kind == dsd_pkg::ACC_DATA && ptr_sel == 2'h0 &&
    req_addr >= 16'h4000 && req_addr <= 16'hBFFF |=> pgm_sel_q)
    else $error("flash window missed");
  hole_nowr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req && tgt == dsd_pkg::TGT_HOLE |=> !wr_q)
    else $error("hole write not dropped");
  start_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    fc_start_q |-> $past(!fc_status_q))
    else $error("start while busy");
  split_kb_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && !e2_enable |=> pgm_kb_q == 6'h20)
    else $error("program size wrong");
  rsp_lat_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && req ##1 clk_en |=> rsp_valid)
    else $error("response latency");
endmodule // dsd_top

// ===== verif/dsd_far_model.sv
// Far-side stand-in: target read bytes and the flash busy line
`timescale 1ns/1ps
module dsd_far_model
(
  input  wire logic        busy_cmd,
  output logic             fc_busy,
  output logic      [7:0]  fc_rdata,
  output logic      [7:0]  reg_rdata,
  output logic      [7:0]  sio_rdata,
  output logic      [7:0]  xio_rdata,
  output logic      [7:0]  sram_rdata,
  output logic      [15:0] pgm_rdata
);
  // ---------------------------------------------------------
  // Targets
  // ---------------------------------------------------------
  // One distinct byte per target so any wrong steer shows at once
  assign reg_rdata  = 8'hA1;
  assign sio_rdata  = 8'hB2;
  assign xio_rdata  = 8'hC3;
  assign sram_rdata = 8'hD4;
  assign fc_rdata   = 8'hE5;
  // Halves differ so a swapped byte pick is caught
  assign pgm_rdata  = 16'h9F6A;
  assign fc_busy    = busy_cmd;
endmodule // dsd_far_model

// ===== verif/data_space_address_decoder_tb_top.sv
// Testbench for the data-space address decoder
`timescale 1ns/1ps
module data_space_address_decoder_tb_top;
  // ---------------------------------------------------------
  // Signals
  // ---------------------------------------------------------
  logic        core_clk, sys_rst, clk_en, req, req_wr, e2_enable, busy_cmd, fc_busy;
  logic        rsp_valid, reg_sel_q, sio_sel_q, xio_sel_q, sram_sel_q, pgm_sel_q;
  logic        fc_sel_q, wr_q, fc_start_q, fc_status_q, s_wr, s_fs;
  logic [2:0]  req_kind;
  logic [1:0]  ptr_sel, sram_size, e2_split;
  logic [5:0]  req_disp, pgm_kb_q;
  logic [7:0]  req_wdata, ptr_x_lo, ptr_x_hi, ptr_y_lo, ptr_y_hi, ptr_z_lo, ptr_z_hi;
  logic [7:0]  rsp_rdata, wdata_q, s_wd;
  logic [4:0]  s_sel;
  logic [7:0]  fc_rdata, reg_rdata, sio_rdata, xio_rdata, sram_rdata;
  logic [6:0]  rsp_target;
  logic [15:0] req_addr, pgm_rdata, local_addr_q, s_la;
  logic [14:0] pgm_word_addr_q, s_pw;
  int          num_errors, n_checks;

  dsd_top dut_u (.core_clk, .sys_rst, .clk_en, .req, .req_wr, .req_kind, .ptr_sel,
    .req_addr, .req_disp, .req_wdata, .sram_size, .e2_enable, .e2_split, .ptr_x_lo,
    .ptr_x_hi, .ptr_y_lo, .ptr_y_hi, .ptr_z_lo, .ptr_z_hi, .fc_busy, .fc_rdata,
    .reg_rdata, .sio_rdata, .xio_rdata,
    .sram_rdata, .pgm_rdata, .rsp_valid, .rsp_rdata, .rsp_target, .reg_sel_q,
    .sio_sel_q, .xio_sel_q, .sram_sel_q, .pgm_sel_q, .fc_sel_q, .wr_q, .local_addr_q,
    .wdata_q, .pgm_word_addr_q, .fc_start_q, .fc_status_q, .pgm_kb_q);
  dsd_far_model far_u (.busy_cmd, .fc_busy, .fc_rdata, .reg_rdata, .sio_rdata,
    .xio_rdata, .sram_rdata, .pgm_rdata);

  always #20 core_clk = ~core_clk;

  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_t(input logic [6:0] got, input logic [6:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t target %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [6:0] etgt(input logic [15:0] a);
    logic [15:0] top;
    top = dsd_pkg::SRAM_BASE + (sram_size == 2'h0 ? dsd_pkg::SRAM_512
        : sram_size == 2'h2 ? dsd_pkg::SRAM_2K : dsd_pkg::SRAM_1K);
    if (a < dsd_pkg::SIO_BASE) return dsd_pkg::TGT_REG;
    if (a < dsd_pkg::XIO_BASE) return dsd_pkg::TGT_SIO;
    if (a <= dsd_pkg::XIO_LAST) return dsd_pkg::TGT_XIO;
    if (a < top) return dsd_pkg::TGT_SRAM;
    if (a >= dsd_pkg::PGM_BASE && a <= dsd_pkg::PGM_LAST) return dsd_pkg::TGT_PGM;
    return dsd_pkg::TGT_HOLE;
  endfunction

  // Called at a falling edge; one request, returns after the response cycle
  task automatic acc(input logic [2:0] k, input logic w, input logic [1:0] p,
                     input logic [15:0] a, input logic [5:0] d, input logic [7:0] wd);
    req_kind = k;
    req_wr = w;
    ptr_sel = p;
    req_addr = a;
    req_disp = d;
    req_wdata = wd;
    req = 1'b1;
    @(negedge core_clk);
    req = 1'b0;
    s_wr = wr_q;
    s_la = local_addr_q;
    s_pw = pgm_word_addr_q;
    s_fs = fc_sel_q;
    s_wd = wdata_q;
    s_sel = {pgm_sel_q, sram_sel_q, xio_sel_q, sio_sel_q, reg_sel_q};
    @(negedge core_clk);
    chk_v(rsp_valid, 1'b1);
  endtask

  // Read request; ea is the address the decoder should end up at
  task automatic probe(input logic [2:0] k, input logic [1:0] p, input logic [15:0] a,
                       input logic [15:0] ea, input logic [5:0] d);
    logic [6:0] t;
    logic [7:0] e;
    t = etgt(ea);
    case (t)
      dsd_pkg::TGT_REG: e = reg_rdata;
      dsd_pkg::TGT_SIO: e = sio_rdata;
      dsd_pkg::TGT_XIO: e = xio_rdata;
      dsd_pkg::TGT_SRAM: e = sram_rdata;
      dsd_pkg::TGT_PGM: e = ea[0] ? pgm_rdata[15:8] : pgm_rdata[7:0];
      default: e = 8'h00;
    endcase
    acc(k, 1'b0, p, a, d, 8'h00);
    chk_t(rsp_target, t);
    chk_v({11'h000, s_sel}, {11'h000, t[4:0]});
    chk_v({8'h00, rsp_rdata}, {8'h00, e});
    if (t == dsd_pkg::TGT_SRAM) chk_v(s_la, ea - dsd_pkg::SRAM_BASE);
    if (t == dsd_pkg::TGT_SIO) chk_v(s_la, ea - dsd_pkg::SIO_BASE);
    if (t == dsd_pkg::TGT_PGM) chk_v({1'b0, s_pw}, (ea - dsd_pkg::PGM_BASE) >> 1);
  endtask

  // Bounded wait for start pulse (sel=0) or busy status (sel=1)
  task automatic wait_hi(input logic sel);
    for (int i = 0; i < 20; i++)
    begin
      if ((sel ? fc_status_q : fc_start_q) === 1'b1) return;
      @(negedge core_clk);
    end
    num_errors++;
    $display("ERROR %0t flash controller wait ran out", $time);
    stop_test();
  endtask

  // ---------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------
  task automatic t_map();
    logic [15:0] al [12] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF,
                             16'h0100, 16'h04FF, 16'h0500, 16'h3FFF, 16'h4000, 16'hBFFF};
    foreach (al[i]) probe(3'h1, 2'h0, al[i], al[i], 6'h00);
    $display("t_map done");
  endtask

  task automatic t_size();
    sram_size = 2'h0;
    probe(3'h1, 2'h0, 16'h02FF, 16'h02FF, 6'h00);
    probe(3'h1, 2'h0, 16'h0300, 16'h0300, 6'h00);
    sram_size = 2'h2;
    probe(3'h1, 2'h0, 16'h08FF, 16'h08FF, 6'h00);
    probe(3'h1, 2'h0, 16'h0900, 16'h0900, 6'h00);
    sram_size = 2'h1;
    $display("t_size done");
  endtask

  task automatic t_ptr();
    {ptr_x_hi, ptr_x_lo} = 16'h0105;
    {ptr_y_hi, ptr_y_lo} = 16'h0100;
    {ptr_z_hi, ptr_z_lo} = 16'h4001;
    probe(3'h1, dsd_pkg::PTR_X, 16'hFFFF, 16'h0105, 6'h05);
    probe(3'h1, dsd_pkg::PTR_Y, 16'hFFFF, 16'h013F, dsd_pkg::DISP_MAX);
    probe(3'h1, dsd_pkg::PTR_Z, 16'hFFFF, 16'h4001, 6'h00);
    {ptr_z_hi, ptr_z_lo} = 16'h00C0;
    probe(3'h1, dsd_pkg::PTR_Z, 16'hFFFF, 16'h00FF, dsd_pkg::DISP_MAX);
    $display("t_ptr done");
  endtask

  task automatic t_io();
    logic [5:0] sc [3] = '{dsd_pkg::SCR0_IO, dsd_pkg::SCR1_IO, dsd_pkg::SCR2_IO};
    probe(3'h2, 2'h0, 16'h0005, 16'h0025, 6'h00);
    // Only six io bits count, so this stays in standard io
    probe(3'h2, 2'h0, 16'h0065, 16'h0045, 6'h00);
    foreach (sc[i]) acc(3'h2, 1'b1, 2'h0, {10'h000, sc[i]}, 6'h00, 8'h3C + 8'(i));
    foreach (sc[i])
    begin
      acc(3'h2, 1'b0, 2'h0, {10'h000, sc[i]}, 6'h00, 8'h00);
      chk_v({8'h00, rsp_rdata}, 16'h003C + 16'(i));
    end
    $display("t_io done");
  endtask

  task automatic t_wr();
    acc(3'h1, 1'b1, 2'h0, 16'h0123, 6'h00, 8'h5A);
    chk_v({s_wr, s_wd, s_la[6:0]}, {1'b1, 8'h5A, 7'h23});
    acc(3'h1, 1'b1, 2'h0, 16'h0600, 6'h00, 8'h5A);
    chk_v(s_wr, 1'b0);
    acc(3'h1, 1'b1, 2'h0, 16'h4000, 6'h00, 8'h5A);
    chk_v(s_wr, 1'b0);
    // Program load from word 1; ea offset by the window base for the compare
    probe(3'h4, 2'h0, 16'h0003, 16'h4003, 6'h00);
    $display("t_wr done");
  endtask

  task automatic t_flash();
    acc(3'h2, 1'b1, 2'h0, {10'h000, dsd_pkg::FADRL_IO}, 6'h00, 8'h10);
    chk_v(s_fs, 1'b1);
    acc(3'h2, 1'b0, 2'h0, {10'h000, dsd_pkg::FDATA_IO}, 6'h00, 8'h00);
    chk_v({8'h00, rsp_rdata}, {8'h00, fc_rdata});
    acc(3'h2, 1'b1, 2'h0, {10'h000, dsd_pkg::FCTRL_IO}, 6'h00, 8'h02);
    wait_hi(1'b0);
    @(negedge core_clk);
    chk_v(fc_start_q, 1'b0);
    busy_cmd = 1'b1;
    wait_hi(1'b1);
    acc(3'h2, 1'b1, 2'h0, {10'h000, dsd_pkg::FCTRL_IO}, 6'h00, 8'h02);
    repeat (8)
    begin
      chk_v(fc_start_q, 1'b0);
      @(negedge core_clk);
    end
    busy_cmd = 1'b0;
    wait_hi(1'b0);
    $display("t_flash done");
  endtask

  task automatic t_split();
    logic [5:0] kb [5] = '{6'h20, 6'h1E, 6'h1C, 6'h18, 6'h10};
    foreach (kb[i])
    begin
      e2_enable = (i != 0);
      e2_split = 2'(i - 1);
      for (int j = 0; j < 10 && pgm_kb_q !== kb[i]; j++) @(negedge core_clk);
      chk_v({10'h000, pgm_kb_q}, {10'h000, kb[i]});
    end
    $display("t_split done");
  endtask

  // Clock enable low must freeze the pipeline with a request standing
  task automatic t_hold();
    clk_en = 1'b0;
    req_kind = 3'h1;
    req_wr = 1'b0;
    ptr_sel = 2'h0;
    req_addr = 16'h0060;
    req = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_v({xio_sel_q, rsp_valid}, 2'h0);
    clk_en = 1'b1;
    @(negedge core_clk);
    req = 1'b0;
    chk_v(xio_sel_q, 1'b1);
    @(negedge core_clk);
    chk_v({rsp_valid, rsp_rdata}, {1'b1, xio_rdata});
    $display("t_hold done");
  endtask

  // ---------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------
  initial
  begin
    {core_clk, req, req_wr, e2_enable, busy_cmd, req_kind, ptr_sel, e2_split} = '0;
    {req_addr, req_disp, req_wdata, ptr_x_lo, ptr_x_hi, ptr_y_lo, ptr_y_hi} = '0;
    {ptr_z_lo, ptr_z_hi} = '0;
    {sys_rst, clk_en} = 2'h3;
    sram_size = 2'h1;
    num_errors = 0;
    n_checks = 0;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    chk_v({10'h000, pgm_kb_q}, 16'h0020);
    chk_t(rsp_target, dsd_pkg::TGT_NONE);
    t_map();
    t_size();
    t_ptr();
    t_io();
    t_wr();
    t_flash();
    t_split();
    t_hold();
    stop_test();
  end
endmodule // data_space_address_decoder_tb_top
